// ### hdl/dac_ctl_pkg.sv
// Purpose: Shared constants and types for the DAC mode-control block
// Assumes: 16-bit control words, index in bits 14..8, data in bits 7..0
// Notes:   Channel vectors use bit 0 for left and bit 1 for right

package dac_ctl_pkg;

  // ****************************************
  // Register indexes
  // ****************************************
  localparam logic [6:0] IDX_ATT_L  = 7'h10;
  localparam logic [6:0] IDX_ATT_R  = 7'h11;
  localparam logic [6:0] IDX_MUTE   = 7'h12;
  localparam logic [6:0] IDX_OUTDE  = 7'h13;
  localparam logic [6:0] IDX_FMT    = 7'h14;
  localparam logic [6:0] IDX_ZFLAG  = 7'h16;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int WORD_BITS    = 16;
  localparam int WORD_TOP_BIT = 15;
  localparam int SOFT_RST_BIT = 7;
  localparam int RATE_BIT     = 6;
  localparam int DE_RATE_LSB  = 5;
  localparam int DM_EN_BIT    = 4;
  localparam int ROLLOFF_BIT  = 5;
  localparam int FLAGMODE_BIT = 2;
  localparam int FLAGPOL_BIT  = 1;
  localparam int PHASE_BIT    = 0;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] ATT_RST   = 8'hFF;
  localparam logic [7:0] MUTE_CODE = 8'h80;
  localparam logic [2:0] FMT_RST   = 3'h5;
  localparam logic [1:0] DE_RATE_RST = 2'h0;
  localparam logic [1:0] PAIR_RST  = 2'h0;
  localparam logic       BIT_RST   = 1'b0;
  localparam int         STEP_FRAMES  = 8;
  localparam int         ZERO_SAMPLES = 1024;

  typedef enum logic [1:0] {OSR_32X, OSR_64X, OSR_128X} osr_t;

  typedef struct packed {
    logic [1:0][7:0] channel_attenuation_code;
    logic [1:0]      channel_soft_mute_bit;
    logic            rate_select_bit;
    logic [1:0]      channel_output_disable;
    logic            deemphasis_enable;
    logic [1:0]      deemphasis_rate_field;
    logic [2:0]      audio_format_field;
    logic            rolloff_select_bit;
    logic            phase_select_bit;
    logic            flag_polarity_bit;
    logic            flag_mode_bit;
  } cfg_t;

  localparam cfg_t CFG_RST = '{
    channel_attenuation_code: {ATT_RST, ATT_RST},
    channel_soft_mute_bit:    PAIR_RST,
    rate_select_bit:          BIT_RST,
    channel_output_disable:   PAIR_RST,
    deemphasis_enable:        BIT_RST,
    deemphasis_rate_field:    DE_RATE_RST,
    audio_format_field:       FMT_RST,
    rolloff_select_bit:       BIT_RST,
    phase_select_bit:         BIT_RST,
    flag_polarity_bit:        BIT_RST,
    flag_mode_bit:            BIT_RST
  };

  typedef struct packed {
    logic        valid;
    logic [23:0] left;
    logic [23:0] right;
  } sample_t;

endpackage : dac_ctl_pkg

// ### hdl/att_ramp.sv
// Purpose: One channel's attenuation ramp and zero-sample detector
// Assumes: step_i pulses once per eight frames, samples on ref_clk_i
// Notes:   Level never drops below the mute code

`timescale 1ns/1ps

module att_ramp #(
  parameter int ZLEN = dac_ctl_pkg::ZERO_SAMPLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       clr_i,
  input  wire logic       step_i,
  input  wire logic       mute_i,
  input  wire logic [7:0] code_i,
  input  wire logic       sample_valid_i,
  input  wire logic       sample_zero_i,
  output logic      [7:0] level_o,
  output logic            zero_o
);
  import dac_ctl_pkg::*;

  localparam int ZW = $clog2(ZLEN + 1);

  logic [7:0]    level_q;
  logic [7:0]    level_d;
  logic [7:0]    target;
  logic [ZW-1:0] zcnt_q;
  logic [ZW-1:0] zcnt_d;
  logic          zero_q;

  assign target  = (mute_i || code_i < MUTE_CODE) ? MUTE_CODE : code_i;
  assign level_d = !step_i ? level_q :
                   (level_q < target) ? level_q + 8'h01 :
                   (level_q > target) ? level_q - 8'h01 : level_q;
  assign zcnt_d  = !sample_valid_i ? zcnt_q :
                   !sample_zero_i ? '0 :
                   (zcnt_q == ZW'(ZLEN)) ? zcnt_q : zcnt_q + ZW'(1);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_q <= ATT_RST;
      zcnt_q  <= '0;
      zero_q  <= 1'b0;
    end else if (clr_i) begin
      level_q <= ATT_RST;
      zcnt_q  <= '0;
      zero_q  <= 1'b0;
    end else begin
      level_q <= level_d;
      zcnt_q  <= zcnt_d;
      zero_q  <= (zcnt_d == ZW'(ZLEN));
    end
  end

  assign level_o = level_q;
  assign zero_o  = zero_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_mute_step;
    step_i && mute_i && !clr_i && level_q > MUTE_CODE;
  endsequence
  sequence s_unmute_step;
    step_i && !mute_i && !clr_i && level_q < target;
  endsequence
  sequence s_nonzero;
    sample_valid_i && !sample_zero_i && !clr_i;
  endsequence

  a_mute_down: assert property (s_mute_step |=> level_q == $past(level_q) - 8'h01)
    else $error("mute ramp did not step down");
  a_unmute_up: assert property (s_unmute_step |=> level_q == $past(level_q) + 8'h01)
    else $error("unmute ramp did not step up");
  a_mute_floor: assert property (level_q >= MUTE_CODE)
    else $error("level below mute code");
  a_level_hold: assert property (!step_i && !clr_i |=> $stable(level_q))
    else $error("level moved without a step");
  a_zero_clear: assert property (s_nonzero |=> !zero_o)
    else $error("zero flag held over a nonzero sample");

endmodule : att_ramp

// ### hdl/dac_mode_ctl.sv
// Purpose: Mode-control registers of a stereo audio DAC behind a
//          three-wire write-only serial control port
// Assumes: ctl_clk_i runs only while ctl_sel_n_i is low; a word is
//          sixteen bits, most significant first
// Notes:   Analog effects leave the block as configuration fields

`timescale 1ns/1ps

module dac_mode_ctl #(
  parameter int ZERO_LEN = dac_ctl_pkg::ZERO_SAMPLES
) (
  input  wire logic                ref_clk_i,
  input  wire logic                reset_i,
  input  wire logic                ctl_clk_i,
  input  wire logic                ctl_sel_n_i,
  input  wire logic                ctl_data_i,
  input  wire logic                frame_clk_i,
  input  wire logic                clk_ratio_low_i,
  input  wire dac_ctl_pkg::sample_t sample_i,
  output dac_ctl_pkg::cfg_t        cfg_o,
  output logic               [7:0] left_level_o,
  output logic               [7:0] right_level_o,
  output dac_ctl_pkg::osr_t        osr_o,
  output logic                     right_zero_flag_pin_o,
  output logic                     left_zero_flag_pin_o
);
  import dac_ctl_pkg::*;

  localparam int CW = $clog2(WORD_BITS);
  localparam int FW = $clog2(STEP_FRAMES);

  // ****************************************
  // Link side: serial word capture
  // ****************************************
  logic                 link_rst;
  logic [CW-1:0]        bit_cnt_q;
  logic [WORD_BITS-2:0] shift_q;
  logic [WORD_BITS-1:0] hold_q;
  logic                 tog_q;
  logic                 last_bit;

  // Frame end clears the bit count without needing a link edge
  assign link_rst = reset_i | ctl_sel_n_i;
  assign last_bit = (bit_cnt_q == CW'(WORD_BITS - 1));

  always_ff @(posedge ctl_clk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + CW'(1);
      shift_q   <= {shift_q[WORD_BITS-3:0], ctl_data_i};
    end
  end

  always_ff @(posedge ctl_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_q <= '0;
      tog_q  <= 1'b0;
    end else if (!ctl_sel_n_i && last_bit) begin
      hold_q <= {shift_q, ctl_data_i};
      tog_q  <= ~tog_q;
    end
  end

  // ****************************************
  // Crossing into the reference clock
  // ****************************************
  logic [2:0] tog_s_q;
  logic       tog_seen_q;
  logic       tog_agree;
  logic       word_ev;

  assign tog_agree = (tog_s_q[1] == tog_s_q[2]);
  assign word_ev   = tog_agree && (tog_s_q[2] != tog_seen_q);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tog_s_q    <= '0;
      tog_seen_q <= 1'b0;
    end else begin
      tog_s_q    <= {tog_s_q[1:0], tog_q};
      tog_seen_q <= tog_agree ? tog_s_q[2] : tog_seen_q;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  logic [6:0] idx;
  logic [7:0] dat;
  logic       wr_ok;
  logic       wr_att_l;
  logic       wr_att_r;
  logic       wr_mute;
  logic       wr_outde;
  logic       wr_fmt;
  logic       wr_zflag;
  logic       soft_rst;

  // Word is stable here: it changed on the link edge that flipped the toggle
  assign idx      = hold_q[WORD_BITS-2:8];
  assign dat      = hold_q[7:0];
  assign wr_ok    = word_ev && !hold_q[WORD_TOP_BIT];
  assign wr_att_l = wr_ok && (idx == IDX_ATT_L);
  assign wr_att_r = wr_ok && (idx == IDX_ATT_R);
  assign wr_mute  = wr_ok && (idx == IDX_MUTE);
  assign wr_outde = wr_ok && (idx == IDX_OUTDE);
  assign wr_fmt   = wr_ok && (idx == IDX_FMT);
  assign wr_zflag = wr_ok && (idx == IDX_ZFLAG);
  assign soft_rst = wr_mute && dat[SOFT_RST_BIT];

  cfg_t cfg_q;
  cfg_t cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (wr_att_l) begin
      cfg_d.channel_attenuation_code[0] = dat;
    end
    if (wr_att_r) begin
      cfg_d.channel_attenuation_code[1] = dat;
    end
    if (wr_mute) begin
      cfg_d.channel_soft_mute_bit = dat[1:0];
      cfg_d.rate_select_bit       = dat[RATE_BIT];
    end
    if (wr_outde) begin
      cfg_d.channel_output_disable = dat[1:0];
      cfg_d.deemphasis_enable      = dat[DM_EN_BIT];
      cfg_d.deemphasis_rate_field  = dat[DE_RATE_LSB+:2];
    end
    if (wr_fmt) begin
      cfg_d.audio_format_field = dat[2:0];
      cfg_d.rolloff_select_bit = dat[ROLLOFF_BIT];
    end
    if (wr_zflag) begin
      cfg_d.phase_select_bit  = dat[PHASE_BIT];
      cfg_d.flag_polarity_bit = dat[FLAGPOL_BIT];
      cfg_d.flag_mode_bit     = dat[FLAGMODE_BIT];
    end
    if (soft_rst) begin
      cfg_d = CFG_RST;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_o = cfg_q;

  // ****************************************
  // Oversampling ratio
  // ****************************************
  osr_t osr_q;
  osr_t osr_d;

  assign osr_d = clk_ratio_low_i ?
                 (cfg_q.rate_select_bit ? OSR_64X : OSR_32X) :
                 (cfg_q.rate_select_bit ? OSR_128X : OSR_64X);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      osr_q <= OSR_64X;
    end else begin
      osr_q <= osr_d;
    end
  end

  assign osr_o = osr_q;

  // ****************************************
  // Ramp tick from the frame clock
  // ****************************************
  logic [2:0]    lr_s_q;
  logic          lr_q;
  logic          lr_agree;
  logic          lr_rise;
  logic [FW-1:0] frm_q;
  logic          step_q;
  logic          frm_last;

  assign lr_agree = (lr_s_q[1] == lr_s_q[2]);
  assign lr_rise  = lr_agree && lr_s_q[2] && !lr_q;
  assign frm_last = (frm_q == FW'(STEP_FRAMES - 1));

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lr_s_q <= '0;
      lr_q   <= 1'b0;
    end else begin
      lr_s_q <= {lr_s_q[1:0], frame_clk_i};
      lr_q   <= lr_agree ? lr_s_q[2] : lr_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      frm_q  <= '0;
      step_q <= 1'b0;
    end else begin
      frm_q  <= lr_rise ? frm_q + FW'(1) : frm_q;
      step_q <= lr_rise && frm_last;
    end
  end

  // ****************************************
  // Channel ramps and zero detect
  // ****************************************
  logic zero_l;
  logic zero_r;
  logic samp_zero_l;
  logic samp_zero_r;

  assign samp_zero_l = (sample_i.left == '0);
  assign samp_zero_r = (sample_i.right == '0);

  att_ramp #(
    .ZLEN (ZERO_LEN)
  ) u_left (
    .ref_clk_i      (ref_clk_i),
    .reset_i        (reset_i),
    .clr_i          (soft_rst),
    .step_i         (step_q),
    .mute_i         (cfg_q.channel_soft_mute_bit[0]),
    .code_i         (cfg_q.channel_attenuation_code[0]),
    .sample_valid_i (sample_i.valid),
    .sample_zero_i  (samp_zero_l),
    .level_o        (left_level_o),
    .zero_o         (zero_l)
  );

  att_ramp #(
    .ZLEN (ZERO_LEN)
  ) u_right (
    .ref_clk_i      (ref_clk_i),
    .reset_i        (reset_i),
    .clr_i          (soft_rst),
    .step_i         (step_q),
    .mute_i         (cfg_q.channel_soft_mute_bit[1]),
    .code_i         (cfg_q.channel_attenuation_code[1]),
    .sample_valid_i (sample_i.valid),
    .sample_zero_i  (samp_zero_r),
    .level_o        (right_level_o),
    .zero_o         (zero_r)
  );

  // ****************************************
  // Zero flag pins
  // ****************************************
  logic pol;
  logic zr_pin_d;
  logic zl_pin_d;
  logic zr_pin_q;
  logic zl_pin_q;

  assign pol      = cfg_q.flag_polarity_bit;
  assign zr_pin_d = cfg_q.flag_mode_bit ? ((zero_l & zero_r) ^ pol) : (zero_r ^ pol);
  assign zl_pin_d = cfg_q.flag_mode_bit ? pol : (zero_l ^ pol);

  // Unassigned pin rests at the inactive level
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      zr_pin_q <= 1'b0;
      zl_pin_q <= 1'b0;
    end else begin
      zr_pin_q <= zr_pin_d;
      zl_pin_q <= zl_pin_d;
    end
  end

  assign right_zero_flag_pin_o = zr_pin_q;
  assign left_zero_flag_pin_o  = zl_pin_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_wr_mute;
    wr_mute && !dat[SOFT_RST_BIT];
  endsequence
  sequence s_ratio_low_fast;
    (clk_ratio_low_i && cfg_q.rate_select_bit) [*2];
  endsequence
  sequence s_ratio_high_fast;
    (!clk_ratio_low_i && cfg_q.rate_select_bit) [*2];
  endsequence

  a_mute_bits: assert property (s_wr_mute |=>
      cfg_q.channel_soft_mute_bit == $past(dat[1:0]))
    else $error("mute bits not written");
  a_soft_reset: assert property (soft_rst |=> cfg_q == CFG_RST)
    else $error("soft reset left a field changed");
  a_fmt_field: assert property (wr_fmt && !soft_rst |=>
      cfg_q.audio_format_field == $past(dat[2:0]))
    else $error("format field not written");
  a_deemph_bits: assert property (wr_outde |=>
      cfg_q.deemphasis_enable == $past(dat[DM_EN_BIT])
      && cfg_q.channel_output_disable == $past(dat[1:0]))
    else $error("deemphasis register not written");
  a_osr_low: assert property (s_ratio_low_fast |-> osr_q == OSR_64X)
    else $error("wrong ratio for low clock");
  a_osr_high: assert property (s_ratio_high_fast |-> osr_q == OSR_128X)
    else $error("wrong ratio for high clock");
  a_flag_indep: assert property (!$past(cfg_q.flag_mode_bit) |->
      left_zero_flag_pin_o == ($past(zero_l) ^ $past(pol)))
    else $error("left flag wrong in separate mode");
  a_flag_common: assert property ($past(cfg_q.flag_mode_bit) |->
      right_zero_flag_pin_o == (($past(zero_l) & $past(zero_r)) ^ $past(pol)))
    else $error("common flag wrong");
  a_step_gap: assert property (step_q |=> !step_q [*8])
    else $error("ramp steps too close");

endmodule : dac_mode_ctl

// ### tb/host_ctl_model.sv
// Purpose: Host controller model driving the three-wire control port
// Assumes: One word per start pulse, most significant bit first
// Notes:   Link clock stands still outside frames; period 15 ns, 45 ns with slow_i set

`timescale 1ns/1ps

module host_ctl_model (
  input  wire logic        start_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] word_i,
  output logic             ctl_clk_o,
  output logic             ctl_sel_n_o,
  output logic             ctl_data_o,
  output logic             busy_o
);
  // ****************************************
  // Frame sender
  // ****************************************
  initial begin
    ctl_clk_o   = 1'b0;
    ctl_sel_n_o = 1'b1;
    ctl_data_o  = 1'b1;
    busy_o      = 1'b0;
    forever begin
      @(posedge start_i);
      busy_o = 1'b1;
      #3.3 ctl_sel_n_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
        if (slow_i) #30;
        #3.7 ctl_data_o = word_i[i];
        #3.8 ctl_clk_o = 1'b1;
        #7.5 ctl_clk_o = 1'b0;
      end
      #4.0 ctl_sel_n_o = 1'b1;
      // Released data line shows the inverse of the last bit
      ctl_data_o = ~ctl_data_o;
      #10 busy_o = 1'b0;
    end
  end
endmodule : host_ctl_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for the DAC mode-control block
// Assumes: Zero detection shortened to four samples; frame clock 40 ns
// Notes:   Configuration results are checked against a queue of expectations

`timescale 1ns/1ps

module testbench;
  import dac_ctl_pkg::*;

  logic        ref_clk = 1'b0;
  logic        reset_i = 1'b1;
  logic        frame_clk = 1'b0;
  logic        ratio_low = 1'b0;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] word = 16'h0000;
  logic        lclk, lsel_n, ldata, busy;
  sample_t     sample = '0;
  cfg_t        cfg_o, exp_cfg, prev_cfg;
  osr_t        osr_o;
  logic [7:0]  left_level_o, right_level_o;
  logic        rpin, lpin;
  cfg_t        exp_q[$];
  logic [31:0] seed = 32'h1BD9;
  int          failures = 0;
  int          checks_done = 0;
  int          cyc = 0;
  logic [7:0]  ztab[5] = '{8'h28, 8'h1A, 8'h0C, 8'h5D, 8'h3E};

  always #5 ref_clk = ~ref_clk;
  initial #2.7 forever #20 frame_clk = ~frame_clk;

  host_ctl_model host (.start_i(start), .slow_i(slow), .word_i(word), .ctl_clk_o(lclk),
                       .ctl_sel_n_o(lsel_n), .ctl_data_o(ldata), .busy_o(busy));

  dac_mode_ctl #(.ZERO_LEN(4)) DUT (
    .ref_clk_i(ref_clk), .reset_i(reset_i), .ctl_clk_i(lclk), .ctl_sel_n_i(lsel_n),
    .ctl_data_i(ldata), .frame_clk_i(frame_clk), .clk_ratio_low_i(ratio_low),
    .sample_i(sample), .cfg_o(cfg_o), .left_level_o(left_level_o),
    .right_level_o(right_level_o), .osr_o(osr_o), .right_zero_flag_pin_o(rpin),
    .left_zero_flag_pin_o(lpin));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [23:0] rnd_nz();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[23:0] | 24'h000001;
  endfunction : rnd_nz

  function automatic cfg_t apply(cfg_t c, logic [6:0] idx, logic [7:0] d);
    case (idx)
      IDX_ATT_L: c.channel_attenuation_code[0] = d;
      IDX_ATT_R: c.channel_attenuation_code[1] = d;
      IDX_MUTE: begin
        c.rate_select_bit = d[RATE_BIT];
        c.channel_soft_mute_bit = d[1:0];
        if (d[SOFT_RST_BIT]) c = CFG_RST;
      end
      IDX_OUTDE: begin
        c.channel_output_disable = d[1:0];
        c.deemphasis_enable = d[DM_EN_BIT];
        c.deemphasis_rate_field = d[DE_RATE_LSB+:2];
      end
      IDX_FMT: begin
        c.audio_format_field = d[2:0];
        c.rolloff_select_bit = d[ROLLOFF_BIT];
      end
      IDX_ZFLAG: begin
        c.phase_select_bit = d[PHASE_BIT];
        c.flag_polarity_bit = d[FLAGPOL_BIT];
        c.flag_mode_bit = d[FLAGMODE_BIT];
      end
      default: ;
    endcase
    return c;
  endfunction : apply

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
    checks_done++;
    if (seen !== expv) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, expv, seen);
    end
  endtask : check

  task automatic send(input logic [15:0] w);
    @(posedge ref_clk);
    word <= w;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    while (busy) @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
  endtask : send

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    cfg_t n;
    n = apply(exp_cfg, idx, d);
    if (n !== exp_cfg) exp_q.push_back(n);
    exp_cfg = n;
    send({1'b0, idx, d});
  endtask : wr

  task automatic wait_level(input bit rt, input logic [7:0] tgt, input int steps);
    int n;
    n = 0;
    while ((rt ? right_level_o : left_level_o) !== tgt && n < steps * 40 + 200) begin
      @(posedge ref_clk);
      n++;
    end
    check("ramp level", rt ? right_level_o : left_level_o, tgt);
    check("ramp pace", n > steps * 28, 1'b1);
  endtask : wait_level

  task automatic samples(input bit lz, input bit rz);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      sample <= '{1'b1, lz ? 24'h0 : rnd_nz(), rz ? 24'h0 : rnd_nz()};
      @(posedge ref_clk);
      sample.valid <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask : samples

  task complete_run();
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // ****************************************
  // Result monitor and timeout
  // ****************************************
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
    if (reset_i) prev_cfg <= CFG_RST;
    else if (cfg_o !== prev_cfg) begin
      prev_cfg <= cfg_o;
      if (exp_q.size() == 0) check("cfg_o unexpected", cfg_o, prev_cfg);
      else check("cfg_o", cfg_o, exp_q.pop_front());
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    exp_cfg = CFG_RST;
    repeat (12) @(posedge ref_clk);
    reset_i <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check("reset cfg", cfg_o, CFG_RST);
    check("reset osr", osr_o, OSR_64X);
    for (int f = 0; f < 8; f++) wr(IDX_FMT, {2'b00, f[0], 2'b00, f[2:0]});
    for (int k = 0; k < 4; k++) wr(IDX_OUTDE, {1'b0, k[1:0], k[0], 2'b00, k[1:0]});
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      ratio_low <= k[1];
      wr(IDX_MUTE, {1'b0, k[0], 6'h00});
      check("osr", osr_o, k[1] ? (k[0] ? OSR_64X : OSR_32X)
                               : (k[0] ? OSR_128X : OSR_64X));
    end
    send({1'b1, IDX_FMT, 8'h00});
    send({1'b0, 7'h15, 8'hFF});
    check("refused words", cfg_o, exp_cfg);
    for (int z = 0; z < 5; z++) begin
      wr(IDX_ZFLAG, {5'h00, ztab[z][2:0]});
      samples(ztab[z][3], ztab[z][4]);
      check("left flag pin", lpin, ztab[z][5]);
      check("right flag pin", rpin, ztab[z][6]);
    end
    slow <= 1'b1;
    wr(IDX_ATT_L, 8'hC0);
    slow <= 1'b0;
    wait_level(1'b0, 8'hC0, 63);
    wr(IDX_MUTE, 8'h01);
    wait_level(1'b0, MUTE_CODE, 64);
    check("right level", right_level_o, ATT_RST);
    wr(IDX_MUTE, 8'h00);
    wait_level(1'b0, 8'hC0, 64);
    wr(IDX_ATT_R, 8'hF0);
    wait_level(1'b1, 8'hF0, 15);
    wr(IDX_MUTE, 8'h02);
    wait_level(1'b1, MUTE_CODE, 112);
    check("left level", left_level_o, 8'hC0);
    wr(IDX_MUTE, 8'h80);
    check("soft reset level", left_level_o, ATT_RST);
    check("soft reset right level", right_level_o, ATT_RST);
    check("queue drained", exp_q.size(), 0);
    complete_run();
  end
endmodule : testbench
